/* fmpg_pkg.sv */
// shared constants and carriers for the frame memory port and gamma table block
package fmpg_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] FMPG_IDX_DATA_LO   = 8'h48;
    localparam logic [7:0] FMPG_IDX_DATA_HI   = 8'h49;
    localparam logic [7:0] FMPG_IDX_RADDR_LO  = 8'h4a;
    localparam logic [7:0] FMPG_IDX_RADDR_MID = 8'h4c;
    localparam logic [7:0] FMPG_IDX_RADDR_HI  = 8'h4e;
    localparam logic [7:0] FMPG_IDX_GAMMA_CTL = 8'h50;
    localparam logic [7:0] FMPG_IDX_GAMMA_IDX = 8'h52;
    localparam logic [7:0] FMPG_IDX_GAMMA_DAT = 8'h54;
    localparam logic [7:0] FMPG_IDX_WIN_BASE  = 8'h60;
    localparam logic [7:0] FMPG_IDX_WIN_SIZE  = 8'h61;

    // field positions and widths
    localparam int FMPG_GAMMA_EN_BIT   = 0;
    localparam int FMPG_GAMMA_MODE_LSB = 1;
    localparam int FMPG_RADDR_HI_W     = 3;

    // reset values
    localparam logic [18:0] FMPG_RADDR_RST     = 19'h00000;
    localparam logic [2:0]  FMPG_GAMMA_CTL_RST = 3'h0;
    localparam logic [7:0]  FMPG_GAMMA_IDX_RST = 8'h00;
    localparam logic [18:0] FMPG_WIN_BASE_RST  = 19'h00000;
    localparam logic [18:0] FMPG_WIN_SIZE_RST  = 19'h00001;

    // read address steps for the two bus widths
    localparam logic [18:0] FMPG_STEP_NARROW = 19'h00001;
    localparam logic [18:0] FMPG_STEP_WIDE   = 19'h00002;

    typedef enum logic [1:0] {
        FMPG_MODE_ALL   = 2'b00,
        FMPG_MODE_RED   = 2'b01,
        FMPG_MODE_GREEN = 2'b10,
        FMPG_MODE_BLUE  = 2'b11
    } fmpg_mode_t;

    // one frame buffer write: pixel address and data word
    typedef struct packed {
        logic [18:0] addr;
        logic [15:0] data;
    } fmpg_fbw_t;

    // one pixel on the display read path; rgb[0] red, rgb[1] green, rgb[2] blue
    typedef struct packed {
        logic            valid;
        logic [2:0][7:0] rgb;
    } fmpg_pix_t;

endpackage

/* fmpg_port.sv */
// frame memory data port, read address and gamma table register block
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps

module fmpg_port
    import fmpg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        host_width_strap,
    output fmpg_fbw_t        fb_wr_o,
    output logic             fb_wr_valid_o,
    input  wire logic        fb_wr_ready_i,
    output logic             fb_rd_req_o,
    output logic      [18:0] fb_rd_addr_o,
    input  wire logic        fb_rd_valid_i,
    input  wire logic [15:0] fb_rd_data_i,
    input  fmpg_pix_t        pix_i,
    output fmpg_pix_t        pix_o
);

    typedef enum logic {
        FMPG_ST_IDLE  = 1'b0,
        FMPG_ST_FETCH = 1'b1
    } fmpg_state_t;

    // bus handshake and read view
    fmpg_state_t     state_q;
    logic            ack_q;
    logic     [31:0] dat_q;
    logic     [31:0] rd_mux;

    // host width strap, two stages from the pin
    logic            strap_meta_q;
    logic            strap_q;
    logic            wide;

    // data port and read address
    logic     [7:0]  data_hi_q;
    logic     [18:0] raddr_q;
    logic     [18:0] raddr_eff;
    logic     [18:0] raddr_step;
    logic     [18:0] raddr_next;
    logic     [18:0] rd_addr_q;
    logic            rd_req_q;

    // gamma control, index and tables
    logic     [2:0]  gamma_ctl_q;
    logic     [7:0]  gamma_idx_q;
    logic     [7:0]  gamma_idx_inc;
    logic     [7:0]  lut [3][256];
    logic     [2:0][7:0] gam;
    logic            lut_wr;
    logic     [1:0]  rd_table;
    fmpg_mode_t      mode;

    // window and frame write pointer
    logic     [18:0] win_base_q;
    logic     [18:0] win_size_q;
    logic     [18:0] wr_cnt_q;
    logic     [18:0] wr_cnt_inc;

    // two-entry write buffer
    fmpg_fbw_t       head_q;
    fmpg_fbw_t       tail_q;
    logic            head_vld_q;
    logic            tail_vld_q;
    fmpg_fbw_t       push_word;
    logic            push;
    logic            pop;
    logic            buf_ready;

    // request decode
    logic     [7:0]  idx;
    logic            req;
    logic            go;
    logic            wr;
    logic            is_data_lo;
    logic            hit_data_hi;
    logic            hit_win_base;
    logic            hit_win_size;
    logic            hit_gamma_ctl;
    logic            hit_gamma_idx;

    // display path
    fmpg_pix_t       pix_q;

    // the strap comes from a pin; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta_q <= 1'b0;
            strap_q      <= 1'b0;
        end else begin
            strap_meta_q <= host_width_strap;
            strap_q      <= strap_meta_q;
        end
    end

    assign wide = strap_q;
    assign mode = fmpg_mode_t'(gamma_ctl_q[FMPG_GAMMA_MODE_LSB +: 2]);
    assign idx  = wb_adr_i[9:2];
    assign req  = wb_cyc_i && wb_stb_i && !ack_q && (state_q == FMPG_ST_IDLE);
    assign wr   = wb_we_i && wb_sel_i[0];
    assign is_data_lo = (idx == FMPG_IDX_DATA_LO);
    // a data port write waits while the buffer is full, so no pixel is lost
    assign go   = req && !(is_data_lo && wb_we_i && !buf_ready);
    assign buf_ready = !tail_vld_q;
    // each data port write with sel[0] high pushes one pixel; the write pointer steps, the read address does not
    assign push = go && wr && is_data_lo;
    assign pop  = head_vld_q && fb_wr_ready_i;

    // 8-bit strap: the low byte alone is a pixel
    assign push_word.addr = 19'(win_base_q + wr_cnt_q);
    assign push_word.data = wide ? {data_hi_q, wb_dat_i[7:0]} : {8'h00, wb_dat_i[7:0]};
    assign lut_wr = go && wr && (idx == FMPG_IDX_GAMMA_DAT);

    // plain register write hits; a write with sel[0] low is acked and ignored
    assign hit_data_hi   = go && wr && (idx == FMPG_IDX_DATA_HI);
    assign hit_win_base  = go && wr && (idx == FMPG_IDX_WIN_BASE);
    assign hit_win_size  = go && wr && (idx == FMPG_IDX_WIN_SIZE);
    assign hit_gamma_ctl = go && wr && (idx == FMPG_IDX_GAMMA_CTL);
    assign hit_gamma_idx = go && wr && (idx == FMPG_IDX_GAMMA_IDX);

    // reads in mode 00 come from the red table
    always_comb begin
        unique case (mode)
            FMPG_MODE_ALL:   rd_table = 2'd0;
            FMPG_MODE_RED:   rd_table = 2'd0;
            FMPG_MODE_GREEN: rd_table = 2'd1;
            FMPG_MODE_BLUE:  rd_table = 2'd2;
        endcase
    end

    // 16-bit strap: reads always land on an even byte
    always_comb begin
        raddr_eff = raddr_q;
        if (wide) begin
            raddr_eff[0] = 1'b0;
        end
    end

    // the step follows the strap so wide reads stay on even bytes
    assign raddr_step    = wide ? FMPG_STEP_WIDE : FMPG_STEP_NARROW;
    assign raddr_next    = 19'(raddr_eff + raddr_step);
    // the pointer sum stays inside 19 bits for any legal window size
    assign wr_cnt_inc    = 19'(wr_cnt_q + 19'h00001);
    // the index carry is dropped on purpose so 255 steps to 0
    assign gamma_idx_inc = 8'(gamma_idx_q + 8'h01);

    // bus sequencing: plain registers answer next cycle, data port reads wait for memory
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FMPG_ST_IDLE;
            ack_q   <= 1'b0;
            dat_q   <= 32'h0000_0000;
        end else begin
            ack_q <= 1'b0;
            unique case (state_q)
                FMPG_ST_IDLE: begin
                    if (go && !wb_we_i && is_data_lo) begin
                        state_q <= FMPG_ST_FETCH;
                    end else if (go) begin
                        ack_q <= 1'b1;
                        dat_q <= rd_mux;
                    end
                end
                FMPG_ST_FETCH: begin
                    if (fb_rd_valid_i) begin
                        ack_q   <= 1'b1;
                        dat_q   <= {24'h000000, fb_rd_data_i[7:0]};
                        state_q <= FMPG_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // register read view; unmapped indices read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            FMPG_IDX_DATA_HI:   rd_mux[7:0] = wide ? data_hi_q : 8'h00;
            FMPG_IDX_RADDR_LO:  rd_mux[7:0] = raddr_q[7:0];
            FMPG_IDX_RADDR_MID: rd_mux[7:0] = raddr_q[15:8];
            FMPG_IDX_RADDR_HI:  rd_mux[FMPG_RADDR_HI_W-1:0] = raddr_q[18:16];
            FMPG_IDX_GAMMA_CTL: rd_mux[2:0] = gamma_ctl_q;
            FMPG_IDX_GAMMA_IDX: rd_mux[7:0] = gamma_idx_q;
            FMPG_IDX_GAMMA_DAT: rd_mux[7:0] = lut[rd_table][gamma_idx_q];
            FMPG_IDX_WIN_BASE:  rd_mux[18:0] = win_base_q;
            FMPG_IDX_WIN_SIZE:  rd_mux[18:0] = win_size_q;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // high data byte: staged by host writes under the 16-bit strap, refilled by each memory read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_hi_q <= 8'h00;
        end else if (state_q == FMPG_ST_FETCH && fb_rd_valid_i) begin
            data_hi_q <= fb_rd_data_i[15:8];
        end else if (hit_data_hi && wide) begin
            data_hi_q <= wb_dat_i[7:0];
        end
    end

    // read address: host loads it, each completed read steps it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raddr_q   <= FMPG_RADDR_RST;
            rd_addr_q <= FMPG_RADDR_RST;
            rd_req_q  <= 1'b0;
        end else if (state_q == FMPG_ST_FETCH) begin
            if (fb_rd_valid_i) begin
                rd_req_q <= 1'b0;
                raddr_q  <= raddr_next;
            end
        end else if (go && !wb_we_i && is_data_lo) begin
            rd_req_q  <= 1'b1; // the read path only ever reads
            rd_addr_q <= raddr_eff;
        end else if (go && wr) begin
            unique case (idx)
                FMPG_IDX_RADDR_LO:  raddr_q[7:0]   <= wb_dat_i[7:0];
                FMPG_IDX_RADDR_MID: raddr_q[15:8]  <= wb_dat_i[7:0];
                FMPG_IDX_RADDR_HI:  raddr_q[18:16] <= wb_dat_i[FMPG_RADDR_HI_W-1:0];
                default:            raddr_q        <= raddr_q;
            endcase
        end
    end

    // window geometry; software must set it before streaming pixels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_base_q <= FMPG_WIN_BASE_RST;
            win_size_q <= FMPG_WIN_SIZE_RST;
        end else if (hit_win_base) begin
            win_base_q <= wb_dat_i[18:0];
        end else if (hit_win_size) begin
            win_size_q <= wb_dat_i[18:0];
        end
    end

    // frame write pointer; a size of zero behaves as one pixel
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_cnt_q <= 19'h00000;
        end else if (hit_win_base || hit_win_size) begin
            wr_cnt_q <= 19'h00000;
        end else if (push) begin
            if (wr_cnt_inc >= win_size_q) begin
                wr_cnt_q <= 19'h00000;
            end else begin
                wr_cnt_q <= wr_cnt_inc;
            end
        end
    end

    // two-entry write buffer; the head drives the memory port directly
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            head_q     <= '0;
            tail_q     <= '0;
            head_vld_q <= 1'b0;
            tail_vld_q <= 1'b0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    if (!head_vld_q) begin
                        head_q     <= push_word;
                        head_vld_q <= 1'b1;
                    end else begin
                        tail_q     <= push_word;
                        tail_vld_q <= 1'b1;
                    end
                end
                2'b01: begin
                    head_q     <= tail_q;
                    head_vld_q <= tail_vld_q;
                    tail_vld_q <= 1'b0;
                end
                2'b11: begin
                    head_q <= tail_vld_q ? tail_q : push_word;
                    if (tail_vld_q) begin
                        tail_q <= push_word;
                    end
                end
                2'b00: begin
                    head_q <= head_q;
                end
            endcase
        end
    end

    // gamma control and table index
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gamma_ctl_q <= FMPG_GAMMA_CTL_RST;
            gamma_idx_q <= FMPG_GAMMA_IDX_RST;
        end else if (hit_gamma_ctl) begin
            gamma_ctl_q <= wb_dat_i[2:0];
        end else if (hit_gamma_idx) begin
            gamma_idx_q <= wb_dat_i[7:0];
        end else if (lut_wr) begin
            gamma_idx_q <= gamma_idx_inc; // wraps 255 to 0
        end
    end

    // per-colour table and lookup; the host must not load tables mid-display
    for (genvar c = 0; c < 3; c++) begin : g_chan
        always_ff @(posedge clk_sys) begin
            if (lut_wr && (mode == FMPG_MODE_ALL || 2'(c + 1) == mode)) begin
                lut[c][gamma_idx_q] <= wb_dat_i[7:0];
            end
        end

        assign gam[c] = lut[c][pix_i.rgb[c]];
    end

    // one register stage for the whole pixel keeps colours and valid aligned
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pix_q <= '0;
        end else if (gamma_ctl_q[FMPG_GAMMA_EN_BIT]) begin
            pix_q <= {pix_i.valid, gam};
        end else begin
            pix_q <= pix_i;
        end
    end

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = dat_q;
    assign fb_wr_o       = head_q;
    assign fb_wr_valid_o = head_vld_q;
    assign fb_rd_req_o   = rd_req_q;
    assign fb_rd_addr_o  = rd_addr_q;
    assign pix_o         = pix_q;

endmodule // fmpg_port

/* fmpg_port_properties.sv */
// port checks for the frame memory port and gamma table block
`timescale 1ns/100ps
module fmpg_port_properties
    import fmpg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic        host_width_strap,
    input wire fmpg_fbw_t   fb_wr_o,
    input wire logic        fb_wr_valid_o,
    input wire logic        fb_wr_ready_i,
    input wire logic        fb_rd_req_o,
    input wire logic [18:0] fb_rd_addr_o,
    input wire logic        fb_rd_valid_i,
    input wire fmpg_pix_t   pix_i,
    input wire fmpg_pix_t   pix_o
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_done;
        fb_rd_req_o && fb_rd_valid_i ##1 wb_ack_o && !fb_rd_req_o;
    endsequence
    property p_rd_done; fb_rd_req_o && fb_rd_valid_i |-> s_rd_done; endproperty
    a_rd_done: assert property (p_rd_done) else $error("read not answered");
    property p_rd_hold; fb_rd_req_o && !fb_rd_valid_i |=> fb_rd_req_o && $stable(fb_rd_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
    property p_rd_cause; $rose(fb_rd_req_o) |-> $past(wb_cyc_i && !wb_we_i); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read without bus read");
    // the strap passes a synchroniser, so only a settled strap counts
    property p_rd_even;
        host_width_strap && $past(host_width_strap, 4) && fb_rd_req_o |-> !fb_rd_addr_o[0];
    endproperty
    a_rd_even: assert property (p_rd_even) else $error("odd wide read");
    property p_wr_hold; fb_wr_valid_o && !fb_wr_ready_i |=> fb_wr_valid_o && $stable(fb_wr_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("stalled word lost");
    property p_wr_cause; $rose(fb_wr_valid_o) |-> wb_ack_o && wb_we_i; endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("frame write without bus write");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_bound; s_req |-> ##[1:40] wb_ack_o; endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("bus hang");
    property p_pix; 1'b1 |=> pix_o.valid == $past(pix_i.valid); endproperty
    a_pix: assert property (p_pix) else $error("pixel latency");
endmodule // fmpg_port_properties

/* fmpg_fb_model.sv */
// frame buffer memory model with stalls and varying read latency
`timescale 1ns/100ps
module fmpg_fb_model
    import fmpg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        rd_req,
    input  wire logic [18:0] rd_addr,
    output logic             wr_ready,
    output logic             rd_valid,
    output logic      [15:0] rd_data
);
    logic [3:0] tick_q;
    logic [2:0] wait_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) tick_q <= 4'h0;
        else tick_q <= tick_q + 4'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) wait_q <= 3'h0;
        else if (!rd_req || rd_valid) wait_q <= 3'h0;
        else wait_q <= wait_q + 3'h1;
    end
    // eight idle cycles in sixteen, long enough to fill the buffer
    assign wr_ready = ~tick_q[3];
    assign rd_valid = rd_req && wait_q == (rd_addr[1] ? 3'h4 : 3'h1);
    // no stale word between answers
    assign rd_data = rd_valid ? rd_addr[15:0] ^ 16'ha5c3 : {4{tick_q}};
endmodule // fmpg_fb_model

/* tb_fmpg_port.sv */
// self-checking bench for the frame memory port and gamma table block
`timescale 1ns/100ps
module tb_fmpg_port
    import fmpg_pkg::*;
    ;
    logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, host_width_strap;
    logic        fb_wr_valid_o, fb_wr_ready_i, fb_rd_req_o, fb_rd_valid_i;
    logic [9:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] fb_rd_data_i, seed;
    logic [18:0] fb_rd_addr_o;
    logic [23:0] rgb;
    fmpg_fbw_t   fb_wr_o;
    fmpg_pix_t   pix_i, pix_o;
    logic [7:0]  key [3] = '{8'h3c, 8'h5a, 8'h96};
    logic [7:0]  rst_idx [5] = '{8'h4a, 8'h4c, 8'h4e, 8'h50, 8'h52};
    logic [34:0] q_rd [$], q_fb [$], q_px [$];
    int          n_errors = 0, comparisons = 0, cycles = 0;
    fmpg_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_width_strap(host_width_strap),
        .fb_wr_o(fb_wr_o), .fb_wr_valid_o(fb_wr_valid_o), .fb_wr_ready_i(fb_wr_ready_i),
        .fb_rd_req_o(fb_rd_req_o), .fb_rd_addr_o(fb_rd_addr_o), .fb_rd_valid_i(fb_rd_valid_i),
        .fb_rd_data_i(fb_rd_data_i), .pix_i(pix_i), .pix_o(pix_o));
    fmpg_fb_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .rd_req(fb_rd_req_o),
        .rd_addr(fb_rd_addr_o), .wr_ready(fb_wr_ready_i), .rd_valid(fb_rd_valid_i),
        .rd_data(fb_rd_data_i));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] mem(input logic [18:0] a);
        return a[7:0] ^ 8'hc3;
    endfunction
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        n_errors += q_rd.size() + q_fb.size() + q_px.size();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        q_rd.push_back({27'h0, exp});
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic px_wr(input logic [18:0] a, input logic [15:0] d, input logic wide);
        q_fb.push_back({a, d});
        if (wide) bus(1'b1, FMPG_IDX_DATA_HI, d[15:8]);
        bus(1'b1, FMPG_IDX_DATA_LO, d[7:0]);
    endtask
    // tables are loaded with correction off so the display sees no half table
    task automatic load(input logic [7:0] ctl, input logic [7:0] k);
        bus(1'b1, FMPG_IDX_GAMMA_CTL, ctl);
        bus(1'b1, FMPG_IDX_GAMMA_IDX, 8'h00);
        for (int i = 0; i < 256; i++) bus(1'b1, FMPG_IDX_GAMMA_DAT, 8'(i) ^ k);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 40000) begin
            n_errors++;
            complete_run();
        end else begin
            if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(35'(wb_dat_o), q_rd.pop_front());
            if (fb_wr_valid_o === 1'b1 && fb_wr_ready_i === 1'b1) check(fb_wr_o, q_fb.pop_front());
            if (pix_o.valid === 1'b1) check(35'(pix_o), q_px.pop_front());
        end
    end
    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, host_width_strap} = 4'h0;
        wb_adr_i = 10'h000;
        wb_dat_i = 32'h00000000;
        pix_i = '0;
        seed = 16'h0007;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rst_idx[i]) rd(rst_idx[i], 8'h00);
        rd(8'h70, 8'h00);
        bus(1'b1, FMPG_IDX_RADDR_LO, 8'h35);
        bus(1'b1, FMPG_IDX_RADDR_MID, 8'h12);
        bus(1'b1, FMPG_IDX_RADDR_HI, 8'hff);
        rd(FMPG_IDX_RADDR_HI, 8'h07);
        rd(FMPG_IDX_DATA_LO, mem(19'h71235));
        rd(FMPG_IDX_RADDR_LO, 8'h36);
        rd(FMPG_IDX_DATA_LO, mem(19'h71236));
        bus(1'b1, FMPG_IDX_GAMMA_CTL, 8'hff);
        rd(FMPG_IDX_GAMMA_CTL, 8'h07);
        bus(1'b1, FMPG_IDX_WIN_BASE, 8'h10);
        bus(1'b1, FMPG_IDX_WIN_SIZE, 8'h03);
        bus(1'b1, FMPG_IDX_DATA_HI, 8'h77);
        rd(FMPG_IDX_DATA_HI, 8'h00);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            px_wr(19'h10 + 19'(i), {8'h00, seed[7:0]}, 1'b0);
        end
        host_width_strap <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus(1'b1, FMPG_IDX_WIN_SIZE, 8'h03);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            px_wr(19'h10 + 19'(i % 3), seed, 1'b1);
        end
        bus(1'b1, FMPG_IDX_RADDR_LO, 8'h35);
        rd(FMPG_IDX_DATA_LO, mem(19'h71234));
        rd(FMPG_IDX_DATA_HI, 8'h12 ^ 8'ha5);
        rd(FMPG_IDX_RADDR_LO, 8'h36);
        load(8'h00, key[0]);
        load(8'h04, key[1]);
        load(8'h06, key[2]);
        rd(FMPG_IDX_GAMMA_DAT, key[2]);
        foreach (key[c]) begin
            bus(1'b1, FMPG_IDX_GAMMA_CTL, {5'h00, 2'(c + 1), 1'b0});
            bus(1'b1, FMPG_IDX_GAMMA_IDX, 8'hfe);
            rd(FMPG_IDX_GAMMA_DAT, 8'hfe ^ key[c]);
        end
        bus(1'b1, FMPG_IDX_GAMMA_CTL, 8'h00);
        rd(FMPG_IDX_GAMMA_DAT, 8'hfe ^ key[0]);
        rd(FMPG_IDX_GAMMA_IDX, 8'hfe);
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, FMPG_IDX_GAMMA_CTL, 8'(e));
            repeat (16) begin
                seed = lfsr(seed);
                rgb = {seed[7:0] ^ seed[15:8], seed};
                q_px.push_back(35'(e ? {1'b1, rgb[23:16] ^ key[2], rgb[15:8] ^ key[1],
                    rgb[7:0] ^ key[0]} : {1'b1, rgb}));
                @(posedge clk_sys);
                pix_i <= {1'b1, rgb};
            end
            @(posedge clk_sys);
            pix_i <= '0;
        end
        repeat (40) @(posedge clk_sys);
        complete_run();
    end
endmodule // tb_fmpg_port
bind fmpg_port fmpg_port_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .host_width_strap(host_width_strap), .fb_wr_o(fb_wr_o), .fb_wr_valid_o(fb_wr_valid_o),
    .fb_wr_ready_i(fb_wr_ready_i), .fb_rd_req_o(fb_rd_req_o), .fb_rd_addr_o(fb_rd_addr_o),
    .fb_rd_valid_i(fb_rd_valid_i), .pix_i(pix_i), .pix_o(pix_o));
